// ### logic/rmp_defs.svh
`ifndef RMP_DEFS_SVH
`define RMP_DEFS_SVH

// ****************************************************************
// Address window and fault reason codes
// ****************************************************************
`define RMP_WIN_HI        12'hFEE
`define RMP_FR_ROOT_NP    8'h01
`define RMP_FR_CTX_NP     8'h02
`define RMP_FR_BAD_PROG   8'h03
`define RMP_FR_RTA_ERR    8'h04
`define RMP_FR_CTP_ERR    8'h05
`define RMP_FR_RSVD       8'h0A
`define RMP_FR_TT_BLOCK   8'h0D
`define RMP_TT_PASS       2'h1
`define RMP_TT_BAD        2'h3
`define RMP_AW_SUPPORTED  8'h04

// ****************************************************************
// Invalidation completion counts and timing
// ****************************************************************
`define RMP_CNT_ZERO      3'h0
`define RMP_CNT_EIGHT     4'h8
`define RMP_CLK_PERIOD_NS 25
`define RMP_INV_TMO_NS    100000000

// ****************************************************************
// Register map (byte addresses) and fields
// ****************************************************************
`define RMP_REG_CTRL      5'h00
`define RMP_REG_STATUS    5'h04
`define RMP_REG_MASK      5'h08
`define RMP_REG_TAGS      5'h0C
`define RMP_REG_FAULT     5'h10
`define RMP_CTRL_EN       0
`define RMP_STS_ICE       0
`define RMP_STS_ITE       1
`define RMP_STS_FLT       2
`define RMP_STS_W         3
`define RMP_FAULT_QUAL    8

`endif

// ### logic/rmp_pkg.sv
`default_nettype none
package rmp_pkg;

   // Outcome of the translated request check
   typedef enum logic [1:0] {
      RMP_RES_PASS  = 2'b00,
      RMP_RES_UR    = 2'b01,
      RMP_RES_FAULT = 2'b10
   } rmp_res_t;

endpackage : rmp_pkg
`default_nettype wire

// ### logic/rmp_xlat_check.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmp_defs.svh"
module rmp_xlat_check
   import rmp_pkg::*;
(
   input  wire logic        en_i,          // Remapping enabled
   input  wire logic        translated_i,  // Request marked translated
   input  wire logic        write_i,       // Write, else read
   input  wire logic [31:0] addr_i,        // Request address
   input  wire logic        root_err_i,    // Root table fetch error
   input  wire logic        root_p_i,      // Root entry present
   input  wire logic        root_rsvd_i,   // Root reserved bits nonzero
   input  wire logic        ctx_err_i,     // Context table fetch error
   input  wire logic        ctx_p_i,       // Context entry present
   input  wire logic        ctx_rsvd_i,    // Context reserved nonzero
   input  wire logic [2:0]  ctx_aw_i,      // address_width_field
   input  wire logic [1:0]  ctx_tt_i,      // Translation type
   output rmp_res_t         res_o,         // Outcome
   output logic [7:0]       reason_o,      // Fault reason
   output logic             qual_o         // Fault is qualified
);
   logic win;
   logic aw_bad;
   logic [7:0] aw_ok;

   assign aw_ok = `RMP_AW_SUPPORTED;
   assign win = (addr_i[31:20] == `RMP_WIN_HI);
   assign aw_bad = !aw_ok[ctx_aw_i];

   always_comb begin
      res_o = RMP_RES_PASS;
      reason_o = 8'h00;
      qual_o = 1'b0;
      if (win && !write_i) begin
         res_o = RMP_RES_UR;                      // see R2
      end else if (translated_i && en_i) begin
         res_o = RMP_RES_FAULT;                   // see R3
         if (win) begin
            res_o = RMP_RES_UR;                   // see R1
         end else if (root_err_i) begin
            reason_o = `RMP_FR_RTA_ERR;           // see R9
         end else if (!root_p_i) begin
            reason_o = `RMP_FR_ROOT_NP;           // see R6
         end else if (root_rsvd_i) begin
            reason_o = `RMP_FR_RSVD;              // see R10
         end else if (ctx_err_i) begin
            reason_o = `RMP_FR_CTP_ERR;           // see R9
         end else if (!ctx_p_i) begin
            reason_o = `RMP_FR_CTX_NP;            // see R7
            qual_o = 1'b1;
         end else if (ctx_rsvd_i) begin
            reason_o = `RMP_FR_RSVD;              // see R10
         end else if (aw_bad || ctx_tt_i == `RMP_TT_BAD) begin
            reason_o = `RMP_FR_BAD_PROG;          // see R8
            qual_o = 1'b1;
         end else if (ctx_tt_i != `RMP_TT_PASS) begin
            reason_o = `RMP_FR_TT_BLOCK;          // see R11
            qual_o = 1'b1;
         end else begin
            res_o = RMP_RES_PASS;                 // see R5
         end
      end
   end

endmodule : rmp_xlat_check
`default_nettype wire

// ### logic/rmp_inv_slot.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmp_defs.svh"
module rmp_inv_slot
   import rmp_pkg::*;
#(
   parameter int TMO_CYCLES = 4
)(
   input  wire logic        core_clk_i,  // Core clock
   input  wire logic        reset_i,     // Sync reset, active high
   input  wire logic        alloc_i,     // Allocate this tag
   input  wire logic [15:0] sid_i,       // Source on allocation
   input  wire logic        hit_i,       // Valid completion names tag
   input  wire logic [3:0]  target_i,    // Expected completions
   output logic             busy_o,      // Tag allocated
   output logic [15:0]      sid_o,       // Owning source
   output logic             done_o,      // Completed, freed
   output logic             tmo_o        // Timed out, freed
);
   localparam int TW = $clog2(TMO_CYCLES + 1);
   localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYCLES - 1);

   typedef struct packed {
      logic          busy;
      logic [15:0]   sid;
      logic [3:0]    cnt;
      logic [TW-1:0] tmr;
   } rmp_slot_t;

   rmp_slot_t q, d;
   logic [3:0] cnt_inc;

   assign cnt_inc = q.cnt + 4'h1;
   assign busy_o = q.busy;
   assign sid_o = q.sid;

   always_comb begin
      d = q;
      done_o = 1'b0;
      tmo_o = 1'b0;
      if (q.busy) begin
         if (hit_i && cnt_inc == target_i) begin
            done_o = 1'b1;                        // see R17
            d.busy = 1'b0;
         end else if (q.tmr == TMO_LAST) begin
            tmo_o = 1'b1;                         // see R18
            d.busy = 1'b0;
         end else begin
            d.tmr = q.tmr + TW'(1);               // see R14
            if (hit_i) begin
               d.cnt = cnt_inc;                   // see R13
            end
         end
      end else if (alloc_i) begin
         d.busy = 1'b1;
         d.sid = sid_i;
         d.cnt = 4'h0;
         d.tmr = '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         q <= '0;                                 // see R19
      end else begin
         q <= d;
      end
   end

endmodule : rmp_inv_slot
`default_nettype wire

// ### logic/rmp_top.sv
// Summary of operation
// R1: With remapping on, translated writes to interrupt window end as UR.
// R2: Every read to the interrupt window ends as UR, translated or not.
// R3: A translated request hitting an error is blocked, UR, fault recorded.
// R4: Qualified faults reported only when fault_report_disable is clear.
// R5: Error-free translated requests pass unchanged with no translation.
// R6: Root entry not present gives reason 1h, non-qualified.
// R7: Context entry not present blocks with reason 2h.
// R8: Unsupported width or type in context gives reason 3h, qualified.
// R9: Root or context table fetch error blocks the request as UR.
// R10: Nonzero reserved bits in present root or context give reason Ah.
// R11: Present context with type 00b or 10b blocks, reason Dh.
// R12: Each invalidation takes a free inval_tag, or waits for one.
// R13: Each allocated tag counts its received completions.
// R14: Allocation starts the tag timer and sends the invalidation message.
// R15: Endpoint answers with tag vector and count of expected messages.
// R16: Completion naming a tag not owned by source is dropped, error flag.
// R17: Valid completion bumps counters; count 0 means 8; match frees tag.
// R18: Timer expiry frees tag, sets timeout flag, may raise fault event.
// R19: Tag count and timeout are parameters; reset frees all tags.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rmp_defs.svh"
module rmp_top
   import rmp_pkg::*;
#(
   parameter int NTAG       = 8,
   parameter int TMO_CYCLES = `RMP_INV_TMO_NS / `RMP_CLK_PERIOD_NS
)(
   input  wire logic            core_clk_i,        // 40 MHz core clock
   input  wire logic            reset_i,           // Sync reset, high
   input  wire logic [4:0]      avs_address_i,     // Byte address
   input  wire logic            avs_read_i,        // Read request
   input  wire logic            avs_write_i,       // Write request
   input  wire logic [31:0]     avs_writedata_i,   // Write data
   input  wire logic [3:0]      avs_byteenable_i,  // Byte enables
   output logic [31:0]          avs_readdata_o,    // Read data
   output logic                 avs_waitrequest_o, // Stall
   output logic                 irq_o,             // Fault event level
   input  wire logic            xr_valid_i,        // Request strobe
   input  wire logic            xr_translated_i,   // Marked translated
   input  wire logic            xr_write_i,        // Write, else read
   input  wire logic [31:0]     xr_addr_i,         // Request address
   input  wire logic            root_err_i,        // Root fetch error
   input  wire logic            root_p_i,          // Root present
   input  wire logic            root_rsvd_i,       // Root reserved set
   input  wire logic            ctx_err_i,         // Context fetch error
   input  wire logic            ctx_p_i,           // Context present
   input  wire logic            ctx_rsvd_i,        // Context reserved set
   input  wire logic [2:0]      ctx_aw_i,          // address_width_field
   input  wire logic [1:0]      ctx_tt_i,          // Translation type
   input  wire logic            ctx_fpd_i,         // fault_report_disable
   output logic                 xr_valid_o,        // Outcome strobe
   output logic                 xr_ur_o,           // Unsupported Request
   output logic [31:0]          xr_addr_o,         // Forwarded address
   output logic                 flt_record_o,      // Fault recorded
   output logic                 flt_report_o,      // Fault to software
   output logic                 flt_qual_o,        // Fault qualified
   output logic [7:0]           flt_reason_o,      // Fault reason
   input  wire logic            inv_req_valid_i,   // Invalidation request
   input  wire logic [15:0]     inv_req_sid_i,     // Target endpoint
   output logic                 inv_req_ack_o,     // Request taken
   output logic                 inv_msg_valid_o,   // Message to endpoint
   output logic [$clog2(NTAG)-1:0] inv_msg_tag_o,  // inval_tag used
   output logic [15:0]          inv_msg_sid_o,     // Target endpoint
   input  wire logic            cpl_valid_i,       // Completion strobe
   input  wire logic [15:0]     cpl_sid_i,         // Responding source
   input  wire logic [NTAG-1:0] cpl_tag_vec_i,     // Tag vector
   input  wire logic [2:0]      cpl_count_i,       // Completion count
   output logic [NTAG-1:0]      inv_done_vec_o     // Tags completed
);
   localparam int TAG_W = $clog2(NTAG);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (NTAG < 2 || NTAG > 32) begin : g_bad_ntag
      $error("NTAG must be 2 to 32");
   end
   if (TMO_CYCLES < 2) begin : g_bad_tmo
      $error("TMO_CYCLES must be at least 2");
   end

   typedef struct packed {
      logic                 waitreq;
      logic [31:0]          rdata;
      logic                 en;
      logic [`RMP_STS_W-1:0] sts;
      logic [`RMP_STS_W-1:0] mask;
      logic                 irq;
      logic                 xr_valid;
      logic                 xr_ur;
      logic [31:0]          xr_addr;
      logic                 flt_rec;
      logic                 flt_rep;
      logic                 flt_qual;
      logic [7:0]           flt_reason;
      logic [7:0]           last_reason;
      logic                 last_qual;
      logic                 inv_ack;
      logic                 inv_msg;
      logic [TAG_W-1:0]     inv_tag;
      logic [15:0]          inv_sid;
      logic [NTAG-1:0]      done_vec;
   } rmp_top_t;

   rmp_top_t q, d;
   rmp_res_t chk_res;
   logic [7:0] chk_reason;
   logic chk_qual;
   logic [NTAG-1:0] busy, done, tmo, alloc, hit;
   logic [15:0] slot_sid [NTAG];
   logic [3:0] target;
   logic cpl_ok;
   logic cpl_bad;

   // ****************************************************************
   // Translated request check
   // ****************************************************************
   rmp_xlat_check u_check (
      .en_i         (q.en),
      .translated_i (xr_translated_i),
      .write_i      (xr_write_i),
      .addr_i       (xr_addr_i),
      .root_err_i   (root_err_i),
      .root_p_i     (root_p_i),
      .root_rsvd_i  (root_rsvd_i),
      .ctx_err_i    (ctx_err_i),
      .ctx_p_i      (ctx_p_i),
      .ctx_rsvd_i   (ctx_rsvd_i),
      .ctx_aw_i     (ctx_aw_i),
      .ctx_tt_i     (ctx_tt_i),
      .res_o        (chk_res),
      .reason_o     (chk_reason),
      .qual_o       (chk_qual)
   );

   // ****************************************************************
   // Invalidation tag slots
   // ****************************************************************
   for (genvar i = 0; i < NTAG; i++) begin : g_slot
      rmp_inv_slot #(.TMO_CYCLES(TMO_CYCLES)) u_slot (
         .core_clk_i (core_clk_i),
         .reset_i    (reset_i),
         .alloc_i    (alloc[i]),
         .sid_i      (inv_req_sid_i),
         .hit_i      (hit[i]),
         .target_i   (target),
         .busy_o     (busy[i]),
         .sid_o      (slot_sid[i]),
         .done_o     (done[i]),
         .tmo_o      (tmo[i])
      );
   end

   // Count of zero stands for eight
   assign target = (cpl_count_i == `RMP_CNT_ZERO) ?
                   `RMP_CNT_EIGHT : {1'b0, cpl_count_i};    // see R17

   always_comb begin
      cpl_ok = 1'b1;
      for (int i = 0; i < NTAG; i++) begin
         if (cpl_tag_vec_i[i] &&
             (!busy[i] || slot_sid[i] != cpl_sid_i)) begin
            cpl_ok = 1'b0;                                   // see R16
         end
      end
   end

   assign cpl_bad = cpl_valid_i && !cpl_ok;
   assign hit = (cpl_valid_i && cpl_ok) ? cpl_tag_vec_i : '0; // see R17

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic                  req;
      logic                  take;
      logic                  found;
      logic [TAG_W-1:0]      idx;
      logic [`RMP_STS_W-1:0] set;
      logic [`RMP_STS_W-1:0] clr;
      req = avs_read_i || avs_write_i;
      take = req && !q.waitreq;
      found = 1'b0;
      idx = '0;
      set = '0;
      clr = '0;
      alloc = '0;
      d = q;

      // Bus slave: one wait state, then answer
      d.waitreq = !(req && q.waitreq);
      if (req && q.waitreq) begin
         unique case (avs_address_i)
            `RMP_REG_CTRL:   d.rdata = {31'h0, q.en};
            `RMP_REG_STATUS: d.rdata = {29'h0, q.sts};
            `RMP_REG_MASK:   d.rdata = {29'h0, q.mask};
            `RMP_REG_TAGS:   d.rdata = 32'(busy);
            `RMP_REG_FAULT:  d.rdata = {23'h0, q.last_qual, q.last_reason};
            default:         d.rdata = 32'h0;
         endcase
      end
      if (take && avs_write_i && avs_byteenable_i[0]) begin
         unique case (avs_address_i)
            `RMP_REG_CTRL:   d.en = avs_writedata_i[`RMP_CTRL_EN];
            `RMP_REG_STATUS: clr = avs_writedata_i[`RMP_STS_W-1:0];
            `RMP_REG_MASK:   d.mask = avs_writedata_i[`RMP_STS_W-1:0];
            default:         ;
         endcase
      end

      // Translated request outcome
      d.xr_valid = xr_valid_i;
      d.xr_ur = xr_valid_i && chk_res != RMP_RES_PASS;       // see R1 R2 R9
      d.xr_addr = xr_addr_i;                                 // see R5
      d.flt_rec = xr_valid_i && chk_res == RMP_RES_FAULT;    // see R3
      d.flt_qual = chk_qual;
      d.flt_reason = chk_reason;
      d.flt_rep = d.flt_rec && (!chk_qual || !ctx_fpd_i);    // see R4
      if (d.flt_rec) begin
         d.last_reason = chk_reason;
         d.last_qual = chk_qual;
      end
      set[`RMP_STS_FLT] = d.flt_rep;

      // Tag allocation, lowest free tag first
      for (int i = NTAG - 1; i >= 0; i--) begin
         if (!busy[i]) begin
            found = 1'b1;
            idx = TAG_W'(i);
         end
      end
      d.inv_ack = inv_req_valid_i && found && !q.inv_ack;    // see R12
      d.inv_msg = d.inv_ack;                                 // see R14
      if (d.inv_ack) begin
         alloc[idx] = 1'b1;
         d.inv_tag = idx;
         d.inv_sid = inv_req_sid_i;
      end
      d.done_vec = done;

      // Sticky status, set wins over clear
      set[`RMP_STS_ICE] = cpl_bad;                           // see R16
      set[`RMP_STS_ITE] = |tmo;                              // see R18
      d.sts = (q.sts & ~clr) | set;
      d.irq = |(d.sts & ~d.mask);
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         q <= '0;
         q.waitreq <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign avs_readdata_o = q.rdata;
   assign avs_waitrequest_o = q.waitreq;
   assign irq_o = q.irq;
   assign xr_valid_o = q.xr_valid;
   assign xr_ur_o = q.xr_ur;
   assign xr_addr_o = q.xr_addr;
   assign flt_record_o = q.flt_rec;
   assign flt_report_o = q.flt_rep;
   assign flt_qual_o = q.flt_qual;
   assign flt_reason_o = q.flt_reason;
   assign inv_req_ack_o = q.inv_ack;
   assign inv_msg_valid_o = q.inv_msg;
   assign inv_msg_tag_o = q.inv_tag;
   assign inv_msg_sid_o = q.inv_sid;
   assign inv_done_vec_o = q.done_vec;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   logic in_win;
   logic chk_go;
   assign in_win = xr_addr_i[31:20] == `RMP_WIN_HI;
   assign chk_go = xr_valid_i && xr_translated_i && q.en && !in_win;

   win_write_ur_a: assert property (                         // see R1
      xr_valid_i && xr_translated_i && xr_write_i && in_win && q.en
      |=> xr_valid_o && xr_ur_o && !flt_record_o)
      else $error("window write not UR");

   win_read_ur_a: assert property (                          // see R2
      xr_valid_i && !xr_write_i && in_win |=> xr_ur_o)
      else $error("window read not UR");

   fault_blocks_a: assert property (                         // see R3
      flt_record_o |-> xr_valid_o && xr_ur_o)
      else $error("fault not blocked");

   report_gate_a: assert property (                          // see R4
      xr_valid_i |=> flt_report_o ==
         (flt_record_o && (!flt_qual_o || !$past(ctx_fpd_i))))
      else $error("fault report gating wrong");

   pass_through_a: assert property (                         // see R5
      xr_valid_i |=> (!xr_ur_o == (xr_addr_o == $past(xr_addr_i))) ||
                     xr_ur_o)
      else $error("pass address changed");

   root_np_a: assert property (                              // see R6
      chk_go && !root_err_i && !root_p_i
      |=> flt_record_o && flt_reason_o == `RMP_FR_ROOT_NP && !flt_qual_o)
      else $error("root not present reason wrong");

   tt_block_a: assert property (                             // see R11
      chk_go && !root_err_i && root_p_i && !root_rsvd_i && !ctx_err_i &&
      ctx_p_i && !ctx_rsvd_i && ctx_aw_i == 3'h2 &&
      (ctx_tt_i == 2'h0 || ctx_tt_i == 2'h2)
      |=> flt_reason_o == `RMP_FR_TT_BLOCK && flt_qual_o)
      else $error("type block reason wrong");

   tag_hold_a: assert property (                             // see R12
      inv_req_valid_i && (&busy) |=> !inv_msg_valid_o)
      else $error("message sent with no free tag");

   msg_tag_busy_a: assert property (                         // see R14
      inv_msg_valid_o |-> busy[inv_msg_tag_o] &&
         slot_sid[inv_msg_tag_o] == inv_msg_sid_o)
      else $error("sent tag not allocated");

   ice_set_a: assert property (                              // see R16
      cpl_bad |=> q.sts[`RMP_STS_ICE])
      else $error("completion error flag not set");

   tmo_free_a: assert property (                             // see R18
      |tmo |=> q.sts[`RMP_STS_ITE] && (busy & $past(tmo)) == '0)
      else $error("timeout did not free tag");

   irq_level_a: assert property (
      irq_o == (|(q.sts & ~q.mask)))
      else $error("interrupt level wrong");

   fault_seen_c: cover property (flt_record_o && flt_report_o);
   inval_done_c: cover property (inv_msg_valid_o ##[1:20] |inv_done_vec_o);
   tag_full_c:   cover property (inv_req_valid_i && (&busy));
   bad_cpl_c:    cover property (cpl_bad);

endmodule : rmp_top
`default_nettype wire

// ### verification/rmp_ep_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Endpoint answering invalidation messages
// ****************************************************************
module rmp_ep_model (
   input  wire logic        clk_i,       // Core clock
   input  wire logic        reset_i,     // Sync reset, active high
   input  wire logic [1:0]  mode_i,      // 0 one,1 mute,2 bad sid,3 eight
   input  wire logic        msg_valid_i, // Invalidation message
   input  wire logic [2:0]  msg_tag_i,   // Tag carried
   input  wire logic [15:0] msg_sid_i,   // Endpoint addressed
   output logic             cpl_valid_o, // Completion strobe
   output logic [15:0]      cpl_sid_o,   // Responding source
   output logic [7:0]       cpl_vec_o,   // Tag vector
   output logic [2:0]       cpl_cnt_o,   // Completion count
   output logic [3:0]       left_o       // Messages still owed
);
   logic [7:0]  vec_q;
   logic [15:0] sid_q;
   always_ff @(posedge clk_i) begin
      cpl_valid_o <= 1'b0;
      cpl_vec_o   <= ~cpl_vec_o;
      cpl_sid_o   <= ~cpl_sid_o;
      cpl_cnt_o   <= ~cpl_cnt_o;
      if (reset_i) begin
         left_o    <= 4'h0;
         cpl_vec_o <= 8'h00;
         cpl_sid_o <= 16'h0000;
         cpl_cnt_o <= 3'h0;
      end else if (msg_valid_i && mode_i != 2'h1) begin
         left_o <= (mode_i == 2'h3) ? 4'h8 : 4'h1;
         vec_q  <= 8'h01 << msg_tag_i;
         sid_q  <= msg_sid_i ^ {15'h0000, mode_i == 2'h2};
      end else if (left_o != 4'h0) begin
         left_o      <= left_o - 4'h1;
         cpl_valid_o <= 1'b1;
         cpl_vec_o   <= vec_q;
         cpl_sid_o   <= sid_q;
         cpl_cnt_o   <= (mode_i == 2'h3) ? 3'h0 : 3'h1;
      end
   end
endmodule : rmp_ep_model
`default_nettype wire

// ### verification/tb_rmp_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_rmp_top;
   logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, xv = 1'b0;
   logic        xt = 1'b0, xw = 1'b0, ie = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wd = 32'h0, xa = 32'h0, rdat, xao, q;
   logic [11:0] lk = 12'h000;
   logic [15:0] isid = 16'h0000, msid, csid;
   logic [1:0]  mode = 2'h0;
   logic [7:0]  vec, done, rsn;
   logic [3:0]  left;
   logic [2:0]  mtag, ccnt;
   logic        wrq, irq, xvo, ur, rec, rep, ack, mv, cv, qual;
   logic [42:0] xq[$];
   logic [7:0]  dq[$];
   int          err_count = 0, checks_done = 0, cyc = 0, seed = 27, i;
   logic [11:0] lk_t[10] = '{12'hC92, 12'h093, 12'h692, 12'h592, 12'h413,
                             12'h4D2, 12'h49A, 12'h490, 12'h496, 12'h492};
   logic [10:0] ex_t[10] = '{11'h704, 11'h701, 11'h70A, 11'h705, 11'h682,
                             11'h70A, 11'h783, 11'h78D, 11'h783, 11'h000};
   rmp_top #(.NTAG(8), .TMO_CYCLES(60)) dut (.core_clk_i(clk), .reset_i(rst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wrq), .irq_o(irq), .xr_valid_i(xv),
      .xr_translated_i(xt), .xr_write_i(xw), .xr_addr_i(xa),
      .root_err_i(lk[11]), .root_p_i(lk[10]), .root_rsvd_i(lk[9]),
      .ctx_err_i(lk[8]), .ctx_p_i(lk[7]), .ctx_rsvd_i(lk[6]),
      .ctx_aw_i(lk[5:3]), .ctx_tt_i(lk[2:1]), .ctx_fpd_i(lk[0]),
      .xr_valid_o(xvo), .xr_ur_o(ur), .xr_addr_o(xao), .flt_record_o(rec),
      .flt_report_o(rep), .flt_qual_o(qual), .flt_reason_o(rsn),
      .inv_req_valid_i(ie), .inv_req_sid_i(isid), .inv_req_ack_o(ack),
      .inv_msg_valid_o(mv), .inv_msg_tag_o(mtag), .inv_msg_sid_o(msid),
      .cpl_valid_i(cv), .cpl_sid_i(csid), .cpl_tag_vec_i(vec),
      .cpl_count_i(ccnt), .inv_done_vec_o(done));
   rmp_ep_model ep (.clk_i(clk), .reset_i(rst), .mode_i(mode),
      .msg_valid_i(mv), .msg_tag_i(mtag), .msg_sid_i(msid), .cpl_valid_o(cv),
      .cpl_sid_o(csid), .cpl_vec_o(vec), .cpl_cnt_o(ccnt), .left_o(left));
   // ****************************************************************
   // Drivers, compares and monitors
   // ****************************************************************
   initial forever #12.5 clk = ~clk;
   task automatic chk(input logic [42:0] g, input logic [42:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      rd  <= ~w;
      wr  <= w;
      adr <= a;
      wd  <= d;
      do @(posedge clk); while (wrq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : av
   task automatic xr(input logic t, w, input logic [31:0] a,
                     input logic [11:0] l, input logic [10:0] e);
      @(posedge clk);
      xv <= 1'b1;
      xt <= t;
      xw <= w;
      xa <= a;
      lk <= l;
      xq.push_back({e, a});
   endtask : xr
   task automatic inv(input logic [2:0] t);
      @(posedge clk);
      ie   <= 1'b1;
      isid <= 16'($random(seed));
      do @(posedge clk); while (ack !== 1'b1);
      chk(43'({mv, mtag, msid}), 43'({1'b1, t, isid}));
      ie <= 1'b0;
   endtask : inv
   always @(negedge clk) begin
      if (xvo === 1'b1)
         chk({ur, rec, rep, rec ? rsn ^ {qual, 7'h00} : 8'h00, xao},
             xq.pop_front());
      if (done !== 8'h00)
         chk(43'({done, left}), 43'({dq.pop_front(), 4'h0}));
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      xr(1'b1, 1'b1, 32'hFEE0_0040, 12'hC92, 11'h000);
      @(posedge clk);
      xv <= 1'b0;
      av(1'b1, 5'h00, 32'h1);
      xr(1'b0, 1'b0, 32'hFEE1_2340, 12'h492, 11'h400);
      xr(1'b1, 1'b0, 32'hFEE0_0000, 12'h492, 11'h400);
      xr(1'b1, 1'b1, 32'hFEEF_FFFC, 12'h492, 11'h400);
      for (i = 0; i < 10; i++)
         xr(1'b1, 1'b1, 32'($random(seed)) & 32'h7FFF_FFFF, lk_t[i], ex_t[i]);
      @(posedge clk);
      xv <= 1'b0;
      av(1'b0, 5'h04, 32'h0);
      chk(43'({irq, q}), 43'({1'b1, 32'h4}));
      av(1'b0, 5'h10, 32'h0);
      chk(43'(q), 43'h103);
      av(1'b1, 5'h04, 32'h7);
      dq.push_back(8'h01);
      inv(3'h0);
      repeat (4) @(posedge clk);
      mode <= 2'h3;
      dq.push_back(8'h01);
      inv(3'h0);
      repeat (12) @(posedge clk);
      mode <= 2'h2;
      inv(3'h0);
      repeat (4) @(posedge clk);
      av(1'b0, 5'h04, 32'h0);
      chk(43'(q), 43'h1);
      mode <= 2'h1;
      for (i = 1; i < 8; i++)
         inv(3'(i));
      av(1'b0, 5'h0C, 32'h0);
      chk(43'(q), 43'hFF);
      inv(3'h0);
      av(1'b1, 5'h08, 32'h3);
      av(1'b0, 5'h04, 32'h0);
      chk(43'({irq, q}), 43'h3);
      tally_and_finish();
   end
endmodule : tb_rmp_top
`default_nettype wire
